// >>> src/lpt_transmitter.sv
//
// Overview of operation
// - Accept 24 colour bits plus line sync, frame sync, data valid, spare.
// - Drive four serial data pairs and one forwarded clock pair.
// - Strobe-edge select high captures inputs on rising pixel clock edge.
// - Strobe-edge select low captures inputs on falling pixel clock edge.
// - Power-down low puts all serial outputs in high impedance.
// - Power-down resets internal state and disables the PLL.
// - No ordering needed between clock, data and power-down release.
// - After clock stops and resumes, relock without toggling power-down.
// - Outputs follow a spread-spectrum modulated pixel clock and data.
// - Lock and valid output within 10 ms of a valid clock.
// - Outputs reach powered-down state within 100 ns of power-down.
//
`default_nettype none
module lpt_transmitter #(
   parameter int LOCK_TIME_CYCLES = lpt_pkg::LOCK_TIME_CYC,
   parameter int LOCK_GOOD = lpt_pkg::LOCK_GOOD_PERIODS
) (
   // System clock and synchronous reset.
   input wire logic clk,
   input wire logic rst,
   // Bit clock from the multiplying PLL, seven times the pixel rate.
   input wire logic ser_clk,
   // Pins from the graphics source.
   input wire lpt_pkg::lpt_pixel_word_s parallel_pixel_inputs,
   input wire logic pixel_clock_pin,
   input wire logic strobe_edge_select,
   input wire logic power_down_n,
   // Serial pins toward the panel.
   output logic [lpt_pkg::NUM_LANES-1:0] serial_lane_pos,
   output logic [lpt_pkg::NUM_LANES-1:0] serial_lane_neg,
   output logic [lpt_pkg::NUM_LANES-1:0] serial_lane_oe,
   output logic forwarded_clock_pos,
   output logic forwarded_clock_neg,
   output logic forwarded_clock_oe,
   output logic pll_enable,
   // AXI4-Lite register slave.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import lpt_pkg::*;

   localparam int PW = WORD_BITS + 3;

   function automatic lpt_reg_sel_e lpt_decode(input logic [7:0] a);
      if (a == REG_CTRL) begin
         lpt_decode = LPT_SEL_CTRL;
      end else if (a == REG_STATUS) begin
         lpt_decode = LPT_SEL_STATUS;
      end else begin
         lpt_decode = LPT_SEL_NONE;
      end
   endfunction : lpt_decode

   function automatic logic [NUM_LANES-1:0] lpt_slot0(input logic [WORD_BITS-1:0] w);
      logic [NUM_LANES-1:0] r;
      r = '0;
      for (int k = 0; k < NUM_LANES; k++) begin
         r[k] = w[k*BITS_PER_LANE];
      end
      return r;
   endfunction : lpt_slot0

   // ---------------- Link domain (ser_clk) ----------------
   logic [PW-1:0] pin_s1;
   logic [PW-1:0] pin_s2;
   logic [2:0] ctl_s1;
   logic [2:0] ctl_s2;
   logic ctrl_standby;
   logic relock_tgl;
   logic relock_d;
   logic pclk_d;
   lpt_link_state_e state;
   lpt_link_state_e next_state;
   logic [3:0] period;
   logic [3:0] next_period;
   logic [3:0] good;
   logic [3:0] next_good;
   logic [WORD_BITS-1:0] shift;
   logic [WORD_BITS-1:0] next_shift;
   logic [6:0] fshift;
   logic [6:0] next_fshift;
   logic link_locked;
   logic next_link_locked;
   logic [NUM_LANES-1:0] next_pos;
   logic [NUM_LANES-1:0] next_neg;
   logic next_oe;
   logic next_fpos;
   logic next_fneg;
   logic next_pll;
   logic strobe;
   logic active;
   logic link_rst;
   logic relock_ev;
   logic [WORD_BITS-1:0] word_in;

   // Every pin and every control from the system domain is double registered.
   always_ff @(posedge ser_clk) begin
      pin_s1 <= {power_down_n, strobe_edge_select, pixel_clock_pin, parallel_pixel_inputs};
      pin_s2 <= pin_s1;
      ctl_s1 <= {rst, ctrl_standby, relock_tgl};
      ctl_s2 <= ctl_s1;
   end

   assign word_in = pin_s2[WORD_BITS-1:0];
   assign link_rst = ctl_s2[2];
   assign relock_ev = ctl_s2[0] ^ relock_d;
   assign active = pin_s2[PW-1] & ~ctl_s2[1];

   always_comb begin
      next_state = state;
      next_period = period;
      next_good = good;
      next_shift = shift;
      next_fshift = fshift;
      next_pos = '0;
      next_fpos = 1'b0;
      next_oe = 1'b0;
      next_pll = 1'b0;
      // Data and clock pass the same two stages, so their alignment is kept.
      if (pin_s2[PW-2]) begin
         strobe = pin_s2[PW-3] & ~pclk_d;
      end else begin
         strobe = ~pin_s2[PW-3] & pclk_d;
      end
      if (!active) begin
         // Standby clears everything and stops the PLL.
         next_state = LPT_OFF;
         next_period = '0;
         next_good = '0;
         next_shift = '0;
         next_fshift = '0;
      end else begin
         next_pll = 1'b1;
         next_oe = 1'b1;
         if (state == LPT_OFF) begin
            next_state = LPT_ACQUIRE;
         end
         // Every strobe restarts the groups, so a bit clock that tracks a modulated pixel clock
         // carries the modulation through to the pairs.
         if (strobe) begin
            next_period = '0;
            next_shift = word_in >> 1;
            next_fshift = FWD_CLK_PATTERN >> 1;
            next_pos = lpt_slot0(word_in);
            next_fpos = FWD_CLK_PATTERN[0];
            // Each bit clock shifts one slot, so a period of seven is a match.
            if (period == 4'(BITS_PER_LANE - 1)) begin
               if (good != 4'(LOCK_GOOD)) begin
                  next_good = good + 4'h1;
               end
            end else begin
               next_good = '0;
               next_state = LPT_ACQUIRE;
            end
         end else begin
            next_shift = shift >> 1;
            next_fshift = fshift >> 1;
            next_pos = lpt_slot0(shift);
            next_fpos = fshift[0];
            if (period != CLK_LOSS_BITS) begin
               next_period = period + 4'h1;
            end else begin
               // A stopped pixel clock drops lock; it is regained on its own.
               next_good = '0;
               next_state = LPT_ACQUIRE;
            end
         end
         if (relock_ev) begin
            next_good = '0;
            next_state = LPT_ACQUIRE;
         end else if (next_state == LPT_ACQUIRE && next_good == 4'(LOCK_GOOD)) begin
            next_state = LPT_LOCKED;
         end
         // Without lock the pairs sit low instead of sending garbage.
         if (next_state != LPT_LOCKED) begin
            next_pos = '0;
            next_fpos = 1'b0;
         end
      end
      next_link_locked = next_state == LPT_LOCKED;
      next_neg = next_oe ? ~next_pos : '0;
      next_fneg = next_oe & ~next_fpos;
   end

   always_ff @(posedge ser_clk) begin
      if (link_rst) begin
         state <= LPT_OFF;
         period <= '0;
         good <= '0;
         shift <= '0;
         fshift <= '0;
         link_locked <= 1'b0;
         pclk_d <= 1'b0;
         relock_d <= 1'b0;
         serial_lane_pos <= '0;
         serial_lane_neg <= '0;
         serial_lane_oe <= '0;
         forwarded_clock_pos <= 1'b0;
         forwarded_clock_neg <= 1'b0;
         forwarded_clock_oe <= 1'b0;
         pll_enable <= 1'b0;
      end else begin
         state <= next_state;
         period <= next_period;
         good <= next_good;
         shift <= next_shift;
         fshift <= next_fshift;
         link_locked <= next_link_locked;
         pclk_d <= pin_s2[PW-3];
         relock_d <= ctl_s2[0];
         serial_lane_pos <= next_pos;
         serial_lane_neg <= next_neg;
         serial_lane_oe <= {NUM_LANES{next_oe}};
         forwarded_clock_pos <= next_fpos;
         forwarded_clock_neg <= next_fneg;
         forwarded_clock_oe <= next_oe;
         pll_enable <= next_pll;
      end
   end

   // ---------------- System domain (clk) ----------------
   logic [1:0] sys_s1;
   logic [1:0] sys_s2;
   logic locked_d;
   logic aw_have;
   logic next_aw_have;
   logic w_have;
   logic next_w_have;
   logic [7:0] aw_addr;
   logic [7:0] next_aw_addr;
   logic [31:0] w_data;
   logic [31:0] next_w_data;
   logic w_lane0;
   logic next_w_lane0;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_arready;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic next_standby;
   logic next_relock_tgl;
   logic [31:0] timer;
   logic [31:0] next_timer;
   logic late;
   logic next_late;
   logic lost;
   logic next_lost;
   logic [31:0] status_word;

   always_ff @(posedge clk) begin
      sys_s1 <= {link_locked, power_down_n};
      sys_s2 <= sys_s1;
   end

   always_comb begin
      status_word = '0;
      status_word[ST_LOCKED] = sys_s2[1];
      status_word[ST_PDN_HIGH] = sys_s2[0];
      status_word[ST_LATE] = late;
      status_word[ST_LOST] = lost;
   end

   always_comb begin
      logic clr_late;
      logic clr_lost;
      clr_late = 1'b0;
      clr_lost = 1'b0;
      next_aw_have = aw_have;
      next_w_have = w_have;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_lane0 = w_lane0;
      next_awready = s_axi_awready;
      next_wready = s_axi_wready;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_arready = s_axi_arready;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      next_standby = ctrl_standby;
      next_relock_tgl = relock_tgl;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_have = 1'b1;
         next_aw_addr = s_axi_awaddr;
         next_awready = 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_have = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_lane0 = s_axi_wstrb[0];
         next_wready = 1'b0;
      end
      if (aw_have && w_have && !s_axi_bvalid) begin
         next_aw_have = 1'b0;
         next_w_have = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         case (lpt_decode(aw_addr))
            LPT_SEL_CTRL: begin
               if (w_lane0) begin
                  next_standby = w_data[CTRL_STANDBY];
                  next_relock_tgl = relock_tgl ^ w_data[CTRL_RELOCK];
               end
            end
            LPT_SEL_STATUS: begin
               clr_late = w_lane0 & w_data[ST_LATE];
               clr_lost = w_lane0 & w_data[ST_LOST];
            end
            default: next_bresp = RESP_SLVERR;
         endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
         next_awready = 1'b1;
         next_wready = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         case (lpt_decode(s_axi_araddr))
            LPT_SEL_CTRL: next_rdata = {30'h0, 1'b0, ctrl_standby};
            LPT_SEL_STATUS: next_rdata = status_word;
            default: begin
               next_rdata = '0;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
         next_arready = 1'b1;
      end
      // Lock watchdog runs only while the link is asked to be up.
      next_timer = '0;
      if (sys_s2[0] && !ctrl_standby && !sys_s2[1]) begin
         next_timer = timer;
         if (timer != 32'(LOCK_TIME_CYCLES)) begin
            next_timer = timer + 32'h1;
         end
      end
      // A new event in the clearing cycle keeps its flag set.
      next_late = (late & ~clr_late) | (timer == 32'(LOCK_TIME_CYCLES - 1));
      next_lost = (lost & ~clr_lost) | (locked_d & ~sys_s2[1]);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_lane0 <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
         ctrl_standby <= CTRL_STANDBY_RESET;
         relock_tgl <= 1'b0;
         timer <= '0;
         late <= 1'b0;
         lost <= 1'b0;
         locked_d <= 1'b0;
      end else begin
         aw_have <= next_aw_have;
         w_have <= next_w_have;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_lane0 <= next_w_lane0;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
         ctrl_standby <= next_standby;
         relock_tgl <= next_relock_tgl;
         timer <= next_timer;
         late <= next_late;
         lost <= next_lost;
         locked_d <= sys_s2[1];
      end
   end

endmodule : lpt_transmitter
`default_nettype wire

// >>> src/lpt_pkg.sv
`default_nettype none
package lpt_pkg;
   localparam int NUM_LANES = 4;
   localparam int BITS_PER_LANE = 7;
   localparam int WORD_BITS = NUM_LANES * BITS_PER_LANE;
   localparam int CLK_HZ = 10_000_000;
   localparam int LOCK_TIME_MS = 10;
   localparam int LOCK_TIME_CYC = LOCK_TIME_MS * (CLK_HZ / 1000);
   localparam int LOCK_GOOD_PERIODS = 4;
   localparam logic [3:0] CLK_LOSS_BITS = 4'hf;
   localparam logic [6:0] FWD_CLK_PATTERN = 7'h0f;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam int CTRL_STANDBY = 0;
   localparam int CTRL_RELOCK = 1;
   localparam int ST_LOCKED = 0;
   localparam int ST_PDN_HIGH = 1;
   localparam int ST_LATE = 2;
   localparam int ST_LOST = 3;
   localparam logic CTRL_STANDBY_RESET = 1'b0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic spare;
      logic data_valid;
      logic frame_sync;
      logic line_sync;
      logic [7:0] blue;
      logic [7:0] green;
      logic [7:0] red;
   } lpt_pixel_word_s;
   typedef enum logic [1:0] {
      LPT_OFF = 2'b00,
      LPT_ACQUIRE = 2'b01,
      LPT_LOCKED = 2'b10
   } lpt_link_state_e;
   typedef enum logic [1:0] {
      LPT_SEL_CTRL = 2'b00,
      LPT_SEL_STATUS = 2'b01,
      LPT_SEL_NONE = 2'b10
   } lpt_reg_sel_e;
endpackage : lpt_pkg
`default_nettype wire

// >>> dv/lpt_tx_checker.sv
`default_nettype none
module lpt_tx_checker (
   // Clocks and reset.
   input wire logic clk,
   input wire logic rst,
   input wire logic ser_clk,
   // Link pins.
   input wire logic power_down_n,
   input wire logic [lpt_pkg::NUM_LANES-1:0] serial_lane_pos,
   input wire logic [lpt_pkg::NUM_LANES-1:0] serial_lane_neg,
   input wire logic [lpt_pkg::NUM_LANES-1:0] serial_lane_oe,
   input wire logic forwarded_clock_pos,
   input wire logic forwarded_clock_neg,
   input wire logic forwarded_clock_oe,
   input wire logic pll_enable,
   // Register bus.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   import lpt_pkg::*;
   // The pin is synchronised first, so the bound is counted in link clocks.
   a_pd_tristate: assert property (
      @(posedge ser_clk) disable iff (rst)
      !power_down_n [*4] |-> serial_lane_oe == '0 && !forwarded_clock_oe
   ) else $error("serial outputs driven in power-down");
   a_pd_pll_off: assert property (
      @(posedge clk) disable iff (rst) !power_down_n [*4] |-> !pll_enable
   ) else $error("pll enabled in power-down");
   a_lane_pair: assert property (
      @(posedge ser_clk) disable iff (rst)
      &serial_lane_oe |-> serial_lane_neg == ~serial_lane_pos
   ) else $error("lane pair not complementary");
   a_fclk_pair: assert property (
      @(posedge ser_clk) disable iff (rst)
      forwarded_clock_oe |-> forwarded_clock_neg == !forwarded_clock_pos
   ) else $error("clock pair not complementary");
   a_fclk_frame: assert property (
      @(posedge ser_clk) disable iff (rst || !power_down_n)
      $rose(forwarded_clock_pos) |-> forwarded_clock_pos [*4] ##1 !forwarded_clock_pos [*3]
   ) else $error("forwarded clock group shape");
   a_bresp_hold: assert property (
      @(posedge clk) disable iff (rst)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
   ) else $error("write response dropped");
   a_rdata_hold: assert property (
      @(posedge clk) disable iff (rst)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
   ) else $error("read data dropped");
   a_wr_answer: assert property (
      @(posedge clk) disable iff (rst)
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid
   ) else $error("write response late");
   a_rd_answer: assert property (
      @(posedge clk) disable iff (rst)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready
   ) else $error("read answer late");
   c_group: cover property (@(posedge ser_clk) $rose(forwarded_clock_pos));
   c_pd_exit: cover property (@(posedge clk) !power_down_n ##1 power_down_n);
   c_slverr: cover property (@(posedge clk) s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : lpt_tx_checker
`default_nettype wire

// >>> dv/lpt_panel_rx.sv
`default_nettype none
module lpt_panel_rx (
   // Link clock.
   input wire logic ser_clk,
   // Serial pairs from the transmitter.
   input wire logic [lpt_pkg::NUM_LANES-1:0] lane_pos,
   input wire logic [lpt_pkg::NUM_LANES-1:0] lane_neg,
   input wire logic [lpt_pkg::NUM_LANES-1:0] lane_oe,
   input wire logic fclk_pos,
   input wire logic fclk_neg,
   input wire logic fclk_oe,
   // Recovered words.
   output logic [lpt_pkg::WORD_BITS-1:0] word,
   output logic word_stb,
   output logic pair_err
);
   timeunit 1ns;
   timeprecision 1ps;
   import lpt_pkg::*;
   logic [WORD_BITS-1:0] acc = '0;
   logic [2:0] slot = 3'd7;
   logic [2:0] cur;
   logic last_fclk = 1'b0;
   initial begin
      word = '0;
      word_stb = 1'b0;
      pair_err = 1'b0;
   end
   // Sampling mid-bit keeps the model clear of the launching edge.
   always @(negedge ser_clk) begin
      word_stb <= 1'b0;
      last_fclk <= fclk_pos;
      if ((&lane_oe && lane_neg !== ~lane_pos) || (fclk_oe && fclk_neg !== !fclk_pos)) begin
         pair_err <= 1'b1;
      end
      // A rising forwarded clock marks slot 0; slot 7 means between groups.
      cur = (fclk_oe && fclk_pos && !last_fclk) ? 3'd0 : slot;
      if (!fclk_oe) begin
         // A released pair carries no bit, so a cut group is dropped.
         slot <= 3'd7;
      end else if (cur != 3'd7) begin
         for (int k = 0; k < NUM_LANES; k++) begin
            acc[BITS_PER_LANE*k+cur] = lane_pos[k];
         end
         slot <= (cur == 3'd6) ? 3'd7 : cur + 3'd1;
         if (cur == 3'd6) begin
            word <= acc;
            word_stb <= 1'b1;
         end
      end
   end
endmodule : lpt_panel_rx
`default_nettype wire

// >>> dv/test_lvds_pixel_link_transmitter.sv
`default_nettype none
module test_lvds_pixel_link_transmitter;
   timeunit 1ns;
   timeprecision 1ps;
   import lpt_pkg::*;
   localparam int LOCK_CYC = 200;
   logic clk = 0, rst = 1, ser_clk = 0, pixel_clock_pin = 0, strobe_edge_select = 0;
   logic power_down_n = 1, run = 0, in_sync = 0, rx_stb, pair_err;
   lpt_pixel_word_s parallel_pixel_inputs = '0;
   logic [NUM_LANES-1:0] serial_lane_pos, serial_lane_neg, serial_lane_oe;
   logic forwarded_clock_pos, forwarded_clock_neg, forwarded_clock_oe, pll_enable;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, w = 0;
   logic [3:0] s_axi_wstrb = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [WORD_BITS-1:0] rx_word;
   logic [2:0] pc = 0;
   logic [65:0] e;
   logic [65:0] rq[$];
   logic [1:0] bq[$];
   logic [WORD_BITS-1:0] exp_q[$];
   int n_fail = 0, samples_checked = 0, n_push = 0, skips = 0;

   lpt_transmitter #(.LOCK_TIME_CYCLES(LOCK_CYC), .LOCK_GOOD(4)) u_dut (.*);
   lpt_panel_rx u_rx (.ser_clk(ser_clk), .lane_pos(serial_lane_pos),
      .lane_neg(serial_lane_neg), .lane_oe(serial_lane_oe), .fclk_pos(forwarded_clock_pos),
      .fclk_neg(forwarded_clock_neg), .fclk_oe(forwarded_clock_oe), .word(rx_word),
      .word_stb(rx_stb), .pair_err(pair_err));

   initial begin
      forever #50 clk = ~clk;
   end
   initial begin
      #13;
      forever #40 ser_clk = ~ser_clk;
   end
   // Seven link clocks per pixel. The word stands around the selected edge and its inverse
   // around the other one, so a capture on the wrong edge sends a word never expected.
   always @(posedge ser_clk) begin
      if (run) begin
         pc <= (pc == 3'd6) ? 3'd0 : pc + 3'd1;
         pixel_clock_pin <= (pc == 3'd6) || (pc < 3'd3);
         if (pc == (strobe_edge_select ? 3'd4 : 3'd1)) begin
            w = $urandom;
            parallel_pixel_inputs <= w[WORD_BITS-1:0];
            if (n_push > 0) begin
               exp_q.push_back(w[WORD_BITS-1:0]);
               n_push--;
            end
         end else if (pc == (strobe_edge_select ? 3'd1 : 3'd4)) begin
            parallel_pixel_inputs <= ~w[WORD_BITS-1:0];
         end
      end
   end
   // Words already in flight when a burst starts are skipped, at most three.
   always @(posedge ser_clk) begin
      if (rx_stb && exp_q.size() != 0) begin
         if (rx_word === exp_q[0]) in_sync = 1;
         else skips++;
         if (in_sync || skips > 3) chk(rx_word === exp_q.pop_front(), "serial word");
      end
   end
   always @(posedge clk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         e = rq.pop_front();
         chk((s_axi_rdata & e[63:32]) === e[31:0] && s_axi_rresp === e[65:64], "read");
      end
      if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp === bq.pop_front(), "write resp");
   end

   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         $display("wrong value at %0t ns: %s", $time, msg);
         n_fail++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                     input logic [1:0] r);
      bit aw = 1, wd = 1, b = 1, late;
      // Half of the writes hold off bready until the response shows, to load the slave.
      late = $urandom_range(1);
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= !late;
      while (aw || wd || b) begin
         @(posedge clk);
         if (aw && s_axi_awready) begin
            aw = 0;
            s_axi_awvalid <= 0;
         end
         if (wd && s_axi_wready) begin
            wd = 0;
            s_axi_wvalid <= 0;
         end
         if (b && s_axi_bvalid && s_axi_bready) begin
            b = 0;
            s_axi_bready <= 0;
         end else if (b && s_axi_bvalid) begin
            s_axi_bready <= 1;
         end
      end
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                     input logic [1:0] r, output logic [31:0] v);
      bit ar = 1, rr = 1, late;
      late = $urandom_range(1);
      v = '0;
      rq.push_back({r, m, x});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= !late;
      while (ar || rr) begin
         @(posedge clk);
         if (ar && s_axi_arready) begin
            ar = 0;
            s_axi_arvalid <= 0;
         end
         if (rr && s_axi_rvalid && s_axi_rready) begin
            rr = 0;
            v = s_axi_rdata;
            s_axi_rready <= 0;
         end else if (rr && s_axi_rvalid) begin
            s_axi_rready <= 1;
         end
      end
      @(posedge clk);
   endtask : rd
   task automatic wait_lock();
      logic [31:0] v;
      int n;
      v = '0;
      n = 0;
      while (v[ST_LOCKED] !== 1'b1 && n < LOCK_CYC / 3) begin
         rd(REG_STATUS, '0, '0, RESP_OKAY, v);
         n++;
      end
      chk(v[ST_LOCKED] === 1'b1, "no lock");
   endtask : wait_lock
   task automatic burst();
      int n;
      n = 0;
      in_sync = 0;
      skips = 0;
      n_push = 16;
      while ((n_push != 0 || exp_q.size() != 0) && n < 400) begin
         @(posedge ser_clk);
         n++;
      end
      chk(n_push == 0 && exp_q.size() == 0, "words lost");
      @(posedge clk);
   endtask : burst
   task automatic stop_test();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      #1ms;
      n_fail++;
      stop_test();
   end
   initial begin
      void'($urandom(19));
      repeat (5) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      rd(REG_CTRL, 32'hffffffff, 32'h0, RESP_OKAY, d);
      rd(REG_STATUS, 32'hb, 32'h2, RESP_OKAY, d);
      wr(8'h10, 32'h1, 4'hf, RESP_SLVERR);
      rd(8'h10, 32'hffffffff, 32'h0, RESP_SLVERR, d);
      wr(REG_CTRL, 32'h1, 4'h0, RESP_OKAY);
      rd(REG_CTRL, 32'hffffffff, 32'h0, RESP_OKAY, d);
      // With no pixel clock the lock timer runs out and leaves its sticky flag.
      repeat (LOCK_CYC + 50) @(posedge clk);
      rd(REG_STATUS, 32'h7, 32'h6, RESP_OKAY, d);
      wr(REG_STATUS, 32'h4, 4'hf, RESP_OKAY);
      run <= 1;
      wait_lock();
      burst();
      run <= 0;
      repeat (30) @(posedge clk);
      rd(REG_STATUS, 32'h9, 32'h8, RESP_OKAY, d);
      wr(REG_STATUS, 32'h8, 4'hf, RESP_OKAY);
      wr(REG_CTRL, 32'h1, 4'hf, RESP_OKAY);
      rd(REG_CTRL, 32'hffffffff, 32'h1, RESP_OKAY, d);
      repeat (4) @(posedge clk);
      chk(pll_enable === 1'b0 && serial_lane_oe === '0, "standby");
      wr(REG_CTRL, 32'h2, 4'hf, RESP_OKAY);
      rd(REG_CTRL, 32'hffffffff, 32'h0, RESP_OKAY, d);
      strobe_edge_select <= 1;
      run <= 1;
      wait_lock();
      burst();
      power_down_n <= 0;
      // Held well beyond the shortest low pulse the pin recognises.
      repeat (12) @(posedge clk);
      chk(serial_lane_oe === '0 && forwarded_clock_oe === 1'b0, "tristate");
      chk(pll_enable === 1'b0, "pll on");
      rd(REG_STATUS, 32'h3, 32'h0, RESP_OKAY, d);
      power_down_n <= 1;
      wait_lock();
      burst();
      chk(pair_err === 1'b0, "pair polarity");
      stop_test();
   end
endmodule : test_lvds_pixel_link_transmitter

bind lpt_transmitter lpt_tx_checker u_chk (.*);
`default_nettype wire
